/* rtl/pawu_pkg.sv */
// Constants and types for the port A pin multiplexer and resume logic.
// Operation
// - Pin A0 is plain I/O or first external interrupt, per alt config bit 0.
// - Pin A1 is plain I/O or second external interrupt, per alt config bit 1.
// - First interrupt input active low; edge when trigger bit is 1, else level.
// - Second interrupt input active low; edge when trigger bit is 1, else level.
// - Asserted resume pin while suspended restarts oscillator and interrupts CPU.
// - Suspend is blocked while the resume pin is held asserted.
// - Resume pin polarity comes from bit 4 of the resume control register.
// - Pin A3 role chosen by resume control bit 7 and output enable bit 3.
// - Secondary resume enabled by control bit 1; polarity from control bit 4.
// - Enabled secondary resume transition while suspended restarts oscillator, interrupts CPU.
// - Enabled, asserted secondary resume level blocks entry to suspend.
// - Pin A2 is plain I/O or input-only FIFO output enable, polarity bit 4.
// - Two-bit interface field picks port, waveform master or slave FIFO mode.
package pawu_pkg;
    localparam int          ALT_IRQ0_BIT  = 0;
    localparam int          ALT_IRQ1_BIT  = 1;
    localparam int          WAKE_EN2_BIT  = 1;
    localparam int          WAKE_POL_BIT  = 4;
    localparam int          WAKE_PIN3_BIT = 7;
    localparam int          PIN_OE_POL_BIT = 4;
    localparam int          PIN_A3        = 3;
    localparam logic [1:0]  IFC_PORT      = 2'h0;
    localparam logic [1:0]  IFC_WAVE      = 2'h2;
    localparam logic [1:0]  IFC_SLAVE     = 2'h3;
    localparam logic [7:0]  CFG_RESET     = 8'h00;

    typedef struct packed {
        logic [5:0] pinMeta;
        logic [5:0] pinSync;
        logic       wakeMeta;
        logic       wakeSync;
        logic [1:0] irqPrev;
        logic       a3Prev;
        logic [5:0] pinOut;
        logic [5:0] pinOe;
        logic [5:0] portIn;
        logic [1:0] irqEvent;
        logic       fifoOe;
        logic [1:0] fifoSel;
        logic       oscRestart;
        logic       cpuWakeIrq;
        logic       suspendBlock;
    } pawu_state_t;
endpackage

/* rtl/pawu_mux.sv */
// Port A low-half pin multiplexer with external interrupts and resume inputs.
`timescale 1ns/100ps
`default_nettype none
module pawu_mux
    import pawu_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [5:0] portPinIn,
    output var  logic [5:0] portPinOut,
    output var  logic [5:0] portPinOe,
    input  wire logic [5:0] portDataOut,
    input  wire logic [5:0] portOeReg,
    output var  logic [5:0] portDataIn,
    input  wire logic [7:0] portAltCfg,
    input  wire logic [7:0] wakeCtrl,
    input  wire logic [7:0] fifoPinPolarity,
    input  wire logic [1:0] interfaceCfg,
    input  wire logic [1:0] extIrqTriggerType,
    input  wire logic       resumePin,
    input  wire logic       cpuSuspended,
    output var  logic [1:0] extIrqEvent,
    output var  logic       fifoSlaveOutputEnable,
    output var  logic [1:0] fifoSelect,
    output var  logic       oscRestart,
    output var  logic       cpuWakeIrq,
    output var  logic       suspendBlock
);
    pawu_state_t st;
    pawu_state_t next_st;

    function automatic logic slaveMode(input logic [1:0] cfg);
        return cfg == IFC_SLAVE;
    endfunction

    logic [1:0] irqAlt;
    logic [1:0] irqLow;
    logic       wakeAsserted;
    logic       a3Alt;
    logic       a3Asserted;
    logic       a3Edge;
    logic [5:0] inputOnly;

    always_comb begin
        next_st = st;
        next_st.pinMeta  = portPinIn;
        next_st.pinSync  = st.pinMeta;
        next_st.wakeMeta = resumePin;
        next_st.wakeSync = st.wakeMeta;
        irqAlt = {portAltCfg[ALT_IRQ1_BIT], portAltCfg[ALT_IRQ0_BIT]};
        irqLow = irqAlt & ~st.pinSync[1:0];
        for (int i = 0; i < 2; i++) begin
            // Edge mode fires once per falling edge; level mode while low.
            if (extIrqTriggerType[i]) begin
                next_st.irqEvent[i] = irqLow[i] & st.irqPrev[i];
            end else begin
                next_st.irqEvent[i] = irqLow[i];
            end
        end
        next_st.irqPrev = ~irqAlt | st.pinSync[1:0];
        wakeAsserted = st.wakeSync == wakeCtrl[WAKE_POL_BIT];
        a3Alt = wakeCtrl[WAKE_PIN3_BIT] & ~portOeReg[PIN_A3];
        a3Asserted = a3Alt & wakeCtrl[WAKE_EN2_BIT]
                   & (st.pinSync[PIN_A3] == wakeCtrl[WAKE_POL_BIT]);
        a3Edge = a3Alt & wakeCtrl[WAKE_EN2_BIT]
               & (st.pinSync[PIN_A3] != st.a3Prev);
        next_st.a3Prev = st.pinSync[PIN_A3];
        next_st.oscRestart = cpuSuspended & (wakeAsserted | a3Edge);
        next_st.cpuWakeIrq = cpuSuspended & (wakeAsserted | a3Edge);
        next_st.suspendBlock = wakeAsserted | a3Asserted;
        // Slave FIFO mode claims A2, A4 and A5 as inputs; other modes leave them.
        inputOnly = {slaveMode(interfaceCfg), slaveMode(interfaceCfg), 1'b0,
                     slaveMode(interfaceCfg), irqAlt};
        inputOnly[PIN_A3] = a3Alt;
        next_st.pinOe  = portOeReg & ~inputOnly;
        next_st.pinOut = portDataOut;
        next_st.portIn = st.pinSync;
        next_st.fifoOe = slaveMode(interfaceCfg)
                       & (st.pinSync[2] == fifoPinPolarity[PIN_OE_POL_BIT]);
        next_st.fifoSel = slaveMode(interfaceCfg) ? st.pinSync[5:4] : 2'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.irqPrev <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    assign portPinOut            = st.pinOut;
    assign portPinOe             = st.pinOe;
    assign portDataIn            = st.portIn;
    assign extIrqEvent           = st.irqEvent;
    assign fifoSlaveOutputEnable = st.fifoOe;
    assign fifoSelect            = st.fifoSel;
    assign oscRestart            = st.oscRestart;
    assign cpuWakeIrq            = st.cpuWakeIrq;
    assign suspendBlock          = st.suspendBlock;

    a_irq0_level_fires: assert property (@(posedge sys_clk) disable iff (!reset_n)
        portAltCfg[0] && !extIrqTriggerType[0] && !st.pinSync[0]
        |=> extIrqEvent[0]) else $error("level irq0 missed");
    a_irq1_gated_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !portAltCfg[1] |=> !extIrqEvent[1]) else $error("irq1 while port");
    a_irq0_edge_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
        extIrqEvent[0] && $past(extIrqTriggerType[0]) && $stable(extIrqTriggerType[0])
        && $stable(portAltCfg[0]) |=> !extIrqEvent[0]) else $error("edge repeat");
    a_wake_no_suspend: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st.wakeSync == wakeCtrl[4] |=> suspendBlock) else $error("suspend not blocked");
    a_wake_restarts_osc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cpuSuspended && st.wakeSync == wakeCtrl[4] |=> oscRestart && cpuWakeIrq)
        else $error("wake lost");
    a_a2_input_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
        interfaceCfg == IFC_SLAVE |=> !portPinOe[2] && !portPinOe[4] && !portPinOe[5])
        else $error("fifo pin driven");
    a_fifo_select_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
        interfaceCfg == IFC_SLAVE |=> fifoSelect == $past(st.pinSync[5:4]))
        else $error("fifo select wrong");
    a_port_mode_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        interfaceCfg == IFC_PORT |=> !fifoSlaveOutputEnable && fifoSelect == 2'h0)
        else $error("fifo active in port mode");
    a_a3_blocks_suspend: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wakeCtrl[7] && !portOeReg[3] && wakeCtrl[1] && st.pinSync[3] == wakeCtrl[4]
        |=> suspendBlock && !portPinOe[3]) else $error("a3 wake ignored");

    // A falling edge is a synced low that was seen high one cycle before.
    // The edge memory is forced high while the pin is not an interrupt, so
    // switching a low pin into interrupt use counts as an edge.
    sequence s_irq0_fall;
        portAltCfg[0] && extIrqTriggerType[0]
        && st.irqPrev[0] && !st.pinSync[0];
    endsequence

    sequence s_irq1_fall;
        portAltCfg[1] && extIrqTriggerType[1]
        && st.irqPrev[1] && !st.pinSync[1];
    endsequence

    sequence s_a3_toggle;
        cpuSuspended && wakeCtrl[7] && !portOeReg[3] && wakeCtrl[1]
        && (st.pinSync[3] != st.a3Prev);
    endsequence

    a_irq0_edge_fires: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        s_irq0_fall |=> extIrqEvent[0]) else $error("edge irq0 missed");
    a_irq1_edge_fires: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        s_irq1_fall |=> extIrqEvent[1]) else $error("edge irq1 missed");

    // A high pin never interrupts, whatever the trigger type.
    a_irq0_high_quiet: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        st.pinSync[0] |=> !extIrqEvent[0]) else $error("irq0 while high");
    a_irq1_level_fires: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        portAltCfg[1] && !extIrqTriggerType[1] && !st.pinSync[1]
        |=> extIrqEvent[1]) else $error("level irq1 missed");
    a_irq0_gated_off: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !portAltCfg[0] |=> !extIrqEvent[0]) else $error("irq0 while port");

    // Interrupt pins are inputs, so their drivers must be off.
    a_irq_pins_input: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        portAltCfg[0] |=> !portPinOe[0]) else $error("irq0 pin driven");

    // The resume outputs only matter while the CPU sleeps; an awake CPU
    // must never see a spurious oscillator restart or wake interrupt.
    a_awake_no_restart: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !cpuSuspended |=> !oscRestart && !cpuWakeIrq)
        else $error("restart while awake");
    a_a3_edge_wakes: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        s_a3_toggle |=> oscRestart && cpuWakeIrq)
        else $error("a3 transition lost");
    a_a3_off_quiet: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !wakeCtrl[1] && st.wakeSync != wakeCtrl[4] |=> !suspendBlock)
        else $error("disabled a3 blocks");
    a_a3_port_drive: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !wakeCtrl[7] || portOeReg[3] |=> portPinOe[3] == $past(portOeReg[3]))
        else $error("a3 port drive wrong");

    // The FIFO output enable follows the pin only in slave mode, and then
    // with the polarity that software selected.
    a_fifo_oe_pol: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        interfaceCfg == IFC_SLAVE |=> fifoSlaveOutputEnable
        == ($past(st.pinSync[2]) == $past(fifoPinPolarity[4])))
        else $error("fifo oe wrong");
    a_a2_port_drive: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        interfaceCfg != IFC_SLAVE |=> portPinOe[2] == $past(portOeReg[2]))
        else $error("a2 port drive wrong");
    a_wave_fifo_idle: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        interfaceCfg == IFC_WAVE |=> !fifoSlaveOutputEnable
        && fifoSelect == 2'h0) else $error("fifo active in wave");

    // Plain port data passes through one register out and three registers in (two sync stages, then one).
    a_port_out_follow: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        reset_n |=> portPinOut == $past(portDataOut))
        else $error("port out wrong");
    a_port_in_route: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        reset_n |=> portDataIn == $past(st.pinSync))
        else $error("port in wrong");
endmodule
`default_nettype wire

/* test/pawu_pin_model.sv */
// External system logic that drives the port A pins and the resume pin.
`timescale 1ns/100ps
`default_nettype none
module pawu_pin_model (
    input  wire logic [5:0] pinWant,
    input  wire logic       wakeWant,
    output wire logic [5:0] portPinIn,
    output wire logic       resumePin
);
    // Board delay keeps pin edges clear of the device clock edge.
    assign #2 portPinIn = pinWant;
    assign #2 resumePin = wakeWant;
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the port A pin multiplexer and resume logic.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pawu_pkg::*;
    logic       clk, resetN, wake, susp, resumeIn, fifoOe, osc, wakeIrq, suspBlk;
    logic [5:0] pins, pinIn, pinOut, pinOe, dataOut, oeReg, dataIn;
    logic [7:0] altCfg, wakeCtrl, fifoPol;
    logic [1:0] ifc, trig, irqEv, fifoSel;
    int         n_mismatch, tests_run, seed, i;
    pawu_pin_model pm (.pinWant(pins), .wakeWant(wake), .portPinIn(pinIn),
        .resumePin(resumeIn));
    pawu_mux dut (.sys_clk(clk), .reset_n(resetN), .portPinIn(pinIn),
        .portPinOut(pinOut), .portPinOe(pinOe), .portDataOut(dataOut),
        .portOeReg(oeReg), .portDataIn(dataIn), .portAltCfg(altCfg),
        .wakeCtrl(wakeCtrl), .fifoPinPolarity(fifoPol), .interfaceCfg(ifc),
        .extIrqTriggerType(trig), .resumePin(resumeIn), .cpuSuspended(susp),
        .extIrqEvent(irqEv), .fifoSlaveOutputEnable(fifoOe),
        .fifoSelect(fifoSel), .oscRestart(osc), .cpuWakeIrq(wakeIrq),
        .suspendBlock(suspBlk));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Inputs move 1 ns after the edge so no race with the sampling edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {n_mismatch, tests_run, resetN, wake, susp} = '0;
        {dataOut, oeReg, altCfg, wakeCtrl, fifoPol, ifc, trig} = '0;
        seed = 32'ha860ffcf;
        pins = 6'h3f;
        cyc(16);
        chk({irqEv, fifoOe, fifoSel, osc, wakeIrq, suspBlk}, 8'h00);
        resetN = 1'b1;
        for (i = 0; i < 20; i++) begin
            {dataOut, oeReg, pins} = 18'($random(seed));
            cyc(3);
            chk(8'(pinOut), 8'(dataOut));
            chk(8'(pinOe), 8'(oeReg));
            chk(8'(dataIn), 8'(pins));
            chk({fifoOe, fifoSel}, 8'h00);
        end
        $display("port mode test done");
        {altCfg, oeReg, trig, pins} = {8'h03, 6'h3f, 2'h1, 6'h3f};
        cyc(3);
        chk(8'(pinOe), 8'h3c);
        pins = 6'h3c;
        cyc(3);
        chk(8'(irqEv), 8'h03);
        cyc(1);
        chk(8'(irqEv), 8'h02);
        chk(8'(irqEv), 8'h02);
        altCfg = 8'h00;
        cyc(1);
        chk(8'(irqEv), 8'h00);
        $display("interrupt test done");
        {ifc, fifoPol} = {IFC_SLAVE, 8'h10};
        for (i = 0; i < 4; i++) begin
            pins = 6'({i[1:0], 4'h4});
            cyc(3);
            chk({fifoOe, fifoSel}, 8'(4 + i));
            chk(8'(pinOe), 8'h0b);
        end
        fifoPol = 8'h00;
        cyc(1);
        chk(8'(fifoOe), 8'h00);
        ifc = IFC_WAVE;
        cyc(1);
        chk(8'(fifoSel), 8'h00);
        $display("slave fifo test done");
        {ifc, susp, wakeCtrl, wake} = {IFC_PORT, 1'b1, 8'h10, 1'b1};
        cyc(3);
        chk({osc, wakeIrq, suspBlk}, 8'h07);
        {wakeCtrl, wake} = {8'h00, 1'b0};
        cyc(3);
        chk({osc, wakeIrq, suspBlk}, 8'h07);
        susp = 1'b0;
        cyc(1);
        chk({osc, wakeIrq, suspBlk}, 8'h01);
        $display("resume pin test done");
        {wake, susp, wakeCtrl, oeReg, pins} = {1'b1, 1'b1, 8'h92, 12'hdf7};
        cyc(3);
        chk({pinOe, suspBlk}, 8'h6f);
        {wake, pins} = {1'b0, 6'h3f};
        cyc(3);
        chk({osc, wakeIrq, suspBlk}, 8'h07);
        cyc(1);
        chk({osc, wakeIrq, suspBlk}, 8'h01);
        wakeCtrl = 8'h90;
        cyc(1);
        chk(8'(suspBlk), 8'h00);
        wakeCtrl = 8'h92;
        cyc(1);
        chk(8'(suspBlk), 8'h01);
        $display("secondary resume test done");
        print_verdict();
    end
endmodule
`default_nettype wire
